// [rtl/pag_defs.svh]
// constants shared by the port access gate
`ifndef PAG_DEFS_SVH
`define PAG_DEFS_SVH
`define PAG_PORT_W 3
`define PAG_EAP_W 32
`define PAG_NPORTS 8
`define PAG_CNT_W 36
// clock rate in hertz and server answer timeout in seconds
`define PAG_CLK_HZ 64'hEE6B280
`define PAG_SRV_TO_S 64'h1E
// unanswered server retransmissions before giving up
`define PAG_MAX_REQ 4'h2
// arbitrary neutral identity values
`define PAG_NAS_IP 32'h0A000001
`define PAG_NAS_ID 32'h00C0FFEE
`define PAG_EAP_NONE 32'h0
`endif

// [rtl/pag_pkg.sv]
// types of the port access gate
`include "pag_defs.svh"
package pag_pkg;
    typedef logic [`PAG_PORT_W-1:0] pag_port_t;
    typedef logic [`PAG_EAP_W-1:0] pag_eap_t;
    typedef logic [`PAG_CNT_W-1:0] pag_cnt_t;
    typedef enum logic [1:0] {
        PAG_EAPOL_PKT = 2'h0,
        PAG_EAPOL_START = 2'h1,
        PAG_EAPOL_LOGOFF = 2'h2
    } pag_eapol_t;
    typedef enum logic [1:0] {
        PAG_TX_REQ_ID = 2'h0,
        PAG_TX_RELAY = 2'h1,
        PAG_TX_SUCCESS = 2'h2,
        PAG_TX_FAILURE = 2'h3
    } pag_cl_kind_t;
    typedef enum logic [1:0] {
        PAG_SRV_CHALLENGE = 2'h0,
        PAG_SRV_ACCEPT = 2'h1,
        PAG_SRV_REJECT = 2'h2
    } pag_srv_kind_t;
    typedef enum logic [3:0] {
        PAG_P_DOWN = 4'h1,
        PAG_P_UNAUTH = 4'h2,
        PAG_P_WSRV = 4'h4,
        PAG_P_AUTH = 4'h8
    } pag_pst_t;
    typedef struct packed {
        pag_port_t port;
        pag_eapol_t kind;
        pag_eap_t eap;
    } pag_cl_rx_t;
    typedef struct packed {
        pag_port_t port;
        pag_cl_kind_t kind;
        pag_eap_t eap;
    } pag_cl_tx_t;
    typedef struct packed {
        pag_port_t port;
        pag_srv_kind_t kind;
        pag_eap_t eap;
    } pag_srv_rx_t;
    typedef struct packed {
        logic [31:0] nas_ip;
        logic [31:0] nas_id;
        pag_port_t port;
        pag_eap_t eap;
    } pag_srv_tx_t;
    typedef struct packed {
        pag_port_t port;
        logic eapol;
    } pag_frm_t;
endpackage : pag_pkg

// [rtl/pag_port_fsm.sv]
// per-port authorization state and relay context
`timescale 1ns/100ps
`include "pag_defs.svh"
module pag_port_fsm #(
    parameter pag_pkg::pag_cnt_t TO_CYC = 36'h1,
    parameter logic [3:0] MAX_REQ = `PAG_MAX_REQ
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // link and mode
    input wire logic link_up_i,
    input wire logic enable_i,
    // decoded client events
    input wire logic rx_start_i,
    input wire logic rx_logoff_i,
    input wire logic rx_eap_i,
    input wire pag_pkg::pag_eap_t rx_data_i,
    // server answer for this port
    input wire logic srv_vld_i,
    input wire pag_pkg::pag_srv_kind_t srv_kind_i,
    input wire pag_pkg::pag_eap_t srv_data_i,
    // grants from the output arbiters
    input wire logic cl_gnt_i,
    input wire logic sv_gnt_i,
    // state and pending work
    output logic auth_o,
    output logic cl_pend_o,
    output pag_pkg::pag_cl_kind_t cl_kind_o,
    output logic sv_pend_o,
    output pag_pkg::pag_eap_t data_o
);
    pag_pkg::pag_pst_t st_q, st_d;
    logic link_q, link_d, clp_q, clp_d, svp_q, svp_d;
    pag_pkg::pag_cl_kind_t clk_q, clk_d;
    pag_pkg::pag_eap_t dat_q, dat_d;
    pag_pkg::pag_cnt_t tmr_q, tmr_d;
    logic [3:0] try_q, try_d;

    ////////////////////////////////////////////////////////////////////
    // next state; a new event overrides a grant in the same cycle
    always_comb begin
        st_d = st_q;
        link_d = link_up_i;
        clp_d = clp_q & ~cl_gnt_i;
        svp_d = svp_q & ~sv_gnt_i;
        clk_d = clk_q;
        dat_d = dat_q;
        try_d = try_q;
        tmr_d = (tmr_q != '0) ? tmr_q - 36'h1 : tmr_q;
        if (!link_up_i || !enable_i) begin
            st_d = pag_pkg::PAG_P_DOWN;
            clp_d = 1'b0;
            svp_d = 1'b0;
            tmr_d = '0;
        end else begin
            case (st_q)
                pag_pkg::PAG_P_DOWN: begin
                    st_d = pag_pkg::PAG_P_UNAUTH;
                    if (!link_q) begin
                        clp_d = 1'b1;
                        clk_d = pag_pkg::PAG_TX_REQ_ID;
                    end
                end
                // silent client: no timer, port simply stays closed
                pag_pkg::PAG_P_UNAUTH: begin
                    if (rx_eap_i) begin
                        dat_d = rx_data_i;
                        svp_d = 1'b1;
                        try_d = 4'h0;
                        tmr_d = TO_CYC;
                        st_d = pag_pkg::PAG_P_WSRV;
                    end
                end
                pag_pkg::PAG_P_WSRV: begin
                    if (srv_vld_i) begin
                        dat_d = srv_data_i;
                        clp_d = 1'b1;
                        tmr_d = '0;
                        st_d = pag_pkg::PAG_P_UNAUTH;
                        clk_d = pag_pkg::PAG_TX_FAILURE;
                        if (srv_kind_i == pag_pkg::PAG_SRV_ACCEPT) begin
                            st_d = pag_pkg::PAG_P_AUTH;
                            clk_d = pag_pkg::PAG_TX_SUCCESS;
                        end else if (srv_kind_i ==
                                     pag_pkg::PAG_SRV_CHALLENGE) begin
                            clk_d = pag_pkg::PAG_TX_RELAY;
                        end
                    end else if (tmr_q == 36'h1) begin
                        if (try_q >= MAX_REQ) begin
                            clp_d = 1'b1;
                            clk_d = pag_pkg::PAG_TX_FAILURE;
                            st_d = pag_pkg::PAG_P_UNAUTH;
                        end else begin
                            svp_d = 1'b1;
                            try_d = try_q + 4'h1;
                            tmr_d = TO_CYC;
                        end
                    end
                end
                pag_pkg::PAG_P_AUTH: begin
                    st_d = pag_pkg::PAG_P_AUTH;
                end
                default: begin
                    st_d = pag_pkg::PAG_P_DOWN;
                end
            endcase
            // a start restarts the exchange from the identity step
            if (rx_start_i && st_q != pag_pkg::PAG_P_DOWN) begin
                clp_d = 1'b1;
                clk_d = pag_pkg::PAG_TX_REQ_ID;
                svp_d = 1'b0;
                tmr_d = '0;
                st_d = pag_pkg::PAG_P_UNAUTH;
            end
            if (rx_logoff_i && st_q != pag_pkg::PAG_P_DOWN) begin
                st_d = pag_pkg::PAG_P_UNAUTH;
                svp_d = 1'b0;
                tmr_d = '0;
            end
        end
    end

    // registers of this port only
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_q <= pag_pkg::PAG_P_DOWN;
            link_q <= 1'b0;
            clp_q <= 1'b0;
            svp_q <= 1'b0;
            clk_q <= pag_pkg::PAG_TX_REQ_ID;
            dat_q <= '0;
            tmr_q <= '0;
            try_q <= 4'h0;
        end else begin
            st_q <= st_d;
            link_q <= link_d;
            clp_q <= clp_d;
            svp_q <= svp_d;
            clk_q <= clk_d;
            dat_q <= dat_d;
            tmr_q <= tmr_d;
            try_q <= try_d;
        end
    end

    assign auth_o = (st_q == pag_pkg::PAG_P_AUTH);
    assign cl_pend_o = clp_q;
    assign cl_kind_o = clk_q;
    assign sv_pend_o = svp_q;
    assign data_o = dat_q;

    ////////////////////////////////////////////////////////////////////
    a_link_down_drop: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !link_up_i |=> st_q == pag_pkg::PAG_P_DOWN && !clp_q)
        else $error("port not closed after link loss");
    a_link_rise_id: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        enable_i && link_up_i && !link_q && !rx_start_i && !rx_logoff_i
        |=> clp_q && clk_q == pag_pkg::PAG_TX_REQ_ID)
        else $error("no identity request after link up");
    a_logoff_closes: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        enable_i && link_up_i && rx_logoff_i && st_q != pag_pkg::PAG_P_DOWN
        |=> st_q == pag_pkg::PAG_P_UNAUTH)
        else $error("logoff did not close the port");
    a_retry_limit: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        enable_i && link_up_i && st_q == pag_pkg::PAG_P_WSRV
        && tmr_q == 36'h1 && try_q == MAX_REQ && !srv_vld_i
        && !rx_start_i && !rx_logoff_i
        |=> st_q == pag_pkg::PAG_P_UNAUTH
        && clk_q == pag_pkg::PAG_TX_FAILURE)
        else $error("server silence not turned into failure");
    a_accept_opens: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        enable_i && link_up_i && st_q == pag_pkg::PAG_P_WSRV && srv_vld_i
        && srv_kind_i == pag_pkg::PAG_SRV_ACCEPT
        && !rx_start_i && !rx_logoff_i
        |=> auth_o && clp_q && clk_q == pag_pkg::PAG_TX_SUCCESS)
        else $error("accept did not open the port");
endmodule : pag_port_fsm

// [rtl/pag_gate.sv]
// port access gate: per-port authenticator, relay and traffic filter
`timescale 1ns/100ps
`include "pag_defs.svh"
// Function
// - auto ports start unauthorized and pass only protocol frames then.
// - successful authentication authorizes the port for all traffic.
// - link up on an auto port sends an identity request.
// - a start frame from the client triggers an identity request.
// - client EAP goes to the server stripped and rewrapped.
// - relayed EAP content is carried unchanged and not interpreted.
// - server EAP goes to the client rewrapped for Ethernet.
// - server packets also carry device address, name and port.
// - server verdict is passed to the client and opens/blocks port.
// - a silent client leaves its port unauthorized.
// - after failure the port stays closed but may retry.
// - unanswered server requests are retried, then count as failure.
// - a logoff frame returns the port to unauthorized.
// - link loss returns the port to unauthorized.
// - with authentication off, client protocol frames are dropped.
// - with authentication globally off, all ports forward.
module pag_gate #(
    parameter int NPORTS = `PAG_NPORTS,
    parameter pag_pkg::pag_cnt_t SRV_TO_CYC =
        pag_pkg::pag_cnt_t'(`PAG_SRV_TO_S * `PAG_CLK_HZ),
    parameter logic [3:0] MAX_REQ = `PAG_MAX_REQ,
    parameter logic [31:0] NAS_IP = `PAG_NAS_IP, // arbitrary value
    parameter logic [31:0] NAS_ID = `PAG_NAS_ID // arbitrary value
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // link pins and configuration
    input wire logic [NPORTS-1:0] link_up_i,
    input wire logic glob_en_i,
    input wire logic [NPORTS-1:0] auto_port_authentication_setting_i,
    // protocol frames from clients
    input wire logic cl_rx_vld_i,
    input wire pag_pkg::pag_cl_rx_t cl_rx_i,
    // packets from the authentication server
    input wire logic srv_rx_vld_i,
    input wire pag_pkg::pag_srv_rx_t srv_rx_i,
    // traffic to be filtered, either direction
    input wire logic frm_vld_i,
    input wire pag_pkg::pag_frm_t frm_i,
    // protocol frames to clients
    output logic cl_tx_vld_o,
    output pag_pkg::pag_cl_tx_t cl_tx_o,
    // packets to the server
    output logic srv_tx_vld_o,
    output pag_pkg::pag_srv_tx_t srv_tx_o,
    // filter verdict and port status
    output logic frm_pass_o,
    output logic frm_drop_o,
    output logic [NPORTS-1:0] port_auth_o
);
    localparam int PW = `PAG_PORT_W;

    logic [NPORTS-1:0] link_s1_q, link_s2_q;
    logic [NPORTS-1:0] en_w, auth_w, clp_w, svp_w, cl_gnt, sv_gnt;
    pag_pkg::pag_cl_kind_t kind_w [NPORTS];
    pag_pkg::pag_eap_t data_w [NPORTS];
    logic cl_vld_q, cl_vld_d, sv_vld_q, sv_vld_d;
    pag_pkg::pag_cl_tx_t cl_tx_q, cl_tx_d;
    pag_pkg::pag_srv_tx_t sv_tx_q, sv_tx_d;
    logic pass_q, pass_d, drop_q, drop_d;
    logic [NPORTS-1:0] pauth_q, pauth_d;

    // one-hot select of a port number
    function automatic logic [NPORTS-1:0] pag_dec(
        input pag_pkg::pag_port_t p
    );
        logic [NPORTS-1:0] r;
        r = '0;
        for (int i = 0; i < NPORTS; i++) begin
            r[i] = (p == pag_pkg::pag_port_t'(i));
        end
        return r;
    endfunction : pag_dec

    // lowest pending port wins, result is {found, index}
    function automatic logic [PW:0] pag_first(
        input logic [NPORTS-1:0] v
    );
        logic [PW:0] r;
        r = '0;
        for (int i = NPORTS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, pag_pkg::pag_port_t'(i)};
            end
        end
        return r;
    endfunction : pag_first

    ////////////////////////////////////////////////////////////////////
    // link pins cross into this clock through two flops
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            link_s1_q <= '0;
            link_s2_q <= '0;
        end else begin
            link_s1_q <= link_up_i;
            link_s2_q <= link_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // one independent controller per port
    logic [NPORTS-1:0] cl_hit, sv_hit;
    assign cl_hit = pag_dec(cl_rx_i.port) & {NPORTS{cl_rx_vld_i}};
    assign sv_hit = pag_dec(srv_rx_i.port) & {NPORTS{srv_rx_vld_i}};
    assign en_w = {NPORTS{glob_en_i}} & auto_port_authentication_setting_i;

    generate
        for (genvar g = 0; g < NPORTS; g++) begin : g_port
            logic ev_ok;
            // protocol frames on a disabled port go nowhere
            assign ev_ok = cl_hit[g] & en_w[g];
            pag_port_fsm #(
                .TO_CYC(SRV_TO_CYC),
                .MAX_REQ(MAX_REQ)
            ) u_port (
                .ref_clk_i(ref_clk_i),
                .sys_rst_i(sys_rst_i),
                .link_up_i(link_s2_q[g]),
                .enable_i(en_w[g]),
                .rx_start_i(ev_ok
                    && cl_rx_i.kind == pag_pkg::PAG_EAPOL_START),
                .rx_logoff_i(ev_ok
                    && cl_rx_i.kind == pag_pkg::PAG_EAPOL_LOGOFF),
                .rx_eap_i(ev_ok
                    && cl_rx_i.kind == pag_pkg::PAG_EAPOL_PKT),
                .rx_data_i(cl_rx_i.eap),
                .srv_vld_i(sv_hit[g]),
                .srv_kind_i(srv_rx_i.kind),
                .srv_data_i(srv_rx_i.eap),
                .cl_gnt_i(cl_gnt[g]),
                .sv_gnt_i(sv_gnt[g]),
                .auth_o(auth_w[g]),
                .cl_pend_o(clp_w[g]),
                .cl_kind_o(kind_w[g]),
                .sv_pend_o(svp_w[g]),
                .data_o(data_w[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // output arbiters; a port waits while a lower port is served
    logic [PW:0] cl_sel, sv_sel;
    assign cl_sel = pag_first(clp_w);
    assign sv_sel = pag_first(svp_w);

    always_comb begin
        cl_vld_d = cl_sel[PW];
        sv_vld_d = sv_sel[PW];
        cl_tx_d = cl_tx_q;
        sv_tx_d = sv_tx_q;
        cl_gnt = '0;
        sv_gnt = '0;
        if (cl_sel[PW]) begin
            cl_gnt = pag_dec(cl_sel[PW-1:0]);
            cl_tx_d.port = cl_sel[PW-1:0];
            cl_tx_d.kind = kind_w[cl_sel[PW-1:0]];
            // identity request has no relayed content of its own
            cl_tx_d.eap = (cl_tx_d.kind == pag_pkg::PAG_TX_REQ_ID)
                ? `PAG_EAP_NONE : data_w[cl_sel[PW-1:0]];
        end
        if (sv_sel[PW]) begin
            sv_gnt = pag_dec(sv_sel[PW-1:0]);
            sv_tx_d.nas_ip = NAS_IP;
            sv_tx_d.nas_id = NAS_ID;
            sv_tx_d.port = sv_sel[PW-1:0];
            sv_tx_d.eap = data_w[sv_sel[PW-1:0]];
        end
    end

    // traffic filter, one cycle of latency
    always_comb begin
        pauth_d = auth_w | ~en_w;
        pass_d = 1'b0;
        drop_d = 1'b0;
        if (frm_vld_i) begin
            if (frm_i.eapol) begin
                pass_d = en_w[frm_i.port];
            end else begin
                pass_d = pauth_d[frm_i.port];
            end
            drop_d = ~pass_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cl_vld_q <= 1'b0;
            sv_vld_q <= 1'b0;
            cl_tx_q <= '0;
            sv_tx_q <= '0;
            pass_q <= 1'b0;
            drop_q <= 1'b0;
            pauth_q <= '0;
        end else begin
            cl_vld_q <= cl_vld_d;
            sv_vld_q <= sv_vld_d;
            cl_tx_q <= cl_tx_d;
            sv_tx_q <= sv_tx_d;
            pass_q <= pass_d;
            drop_q <= drop_d;
            pauth_q <= pauth_d;
        end
    end

    assign cl_tx_vld_o = cl_vld_q;
    assign cl_tx_o = cl_tx_q;
    assign srv_tx_vld_o = sv_vld_q;
    assign srv_tx_o = sv_tx_q;
    assign frm_pass_o = pass_q;
    assign frm_drop_o = drop_q;
    assign port_auth_o = pauth_q;

    ////////////////////////////////////////////////////////////////////
    a_unauth_blocks: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        frm_vld_i && !frm_i.eapol && en_w[frm_i.port]
        && !auth_w[frm_i.port] |=> frm_drop_o && !frm_pass_o)
        else $error("data passed an unauthorized port");
    a_glob_off_fwd: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !glob_en_i |=> port_auth_o == {NPORTS{1'b1}})
        else $error("port closed while authentication is off");
    a_eapol_dropped: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        frm_vld_i && frm_i.eapol && !en_w[frm_i.port] |=> frm_drop_o)
        else $error("protocol frame passed a disabled port");
    a_srv_attrs: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        svp_w != '0 |=> srv_tx_vld_o && srv_tx_o.nas_ip == NAS_IP
        && srv_tx_o.nas_id == NAS_ID
        && srv_tx_o.eap == $past(data_w[sv_sel[PW-1:0]]))
        else $error("server packet missing attributes or content");
endmodule : pag_gate

// [sim/pag_partner_model.sv]
// client and authentication server model facing the gate
`timescale 1ns/100ps
module pag_partner_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // behaviour controls from the bench
    input wire logic cl_ans_i,
    input wire logic srv_ans_i,
    input wire logic srv_ok_i,
    input wire logic [3:0] srv_dly_i,
    // gate outputs
    input wire logic cl_tx_vld_i,
    input wire pag_pkg::pag_cl_tx_t cl_tx_i,
    input wire logic srv_tx_vld_i,
    input wire pag_pkg::pag_srv_tx_t srv_tx_i,
    // frames toward the gate
    output logic cl_vld_o,
    output pag_pkg::pag_cl_rx_t cl_o,
    output logic srv_vld_o,
    output pag_pkg::pag_srv_rx_t srv_o
);
    logic s_busy_q;
    logic [3:0] s_cnt_q;
    pag_pkg::pag_srv_tx_t s_req_q;

    ////////////////////////////////////////////////////////////////
    // client: identity on request, reply on relayed challenge
    always @(posedge ref_clk_i) begin
        cl_vld_o <= 1'b0;
        cl_o <= ~cl_o; // idle data keeps moving, never holds
        if (sys_rst_i) begin
            cl_o <= '0;
        end else if (cl_tx_vld_i && cl_ans_i &&
                cl_tx_i.kind != pag_pkg::PAG_TX_SUCCESS &&
                cl_tx_i.kind != pag_pkg::PAG_TX_FAILURE) begin
            cl_vld_o <= 1'b1;
            cl_o.port <= cl_tx_i.port;
            cl_o.kind <= pag_pkg::PAG_EAPOL_PKT;
            cl_o.eap <= (cl_tx_i.kind == pag_pkg::PAG_TX_REQ_ID) ?
                {28'h1ABCD00, 1'b0, cl_tx_i.port} :
                {4'h2, cl_tx_i.eap[27:0]};
        end
    end

    // server: one request at a time, answered after a set delay
    always @(posedge ref_clk_i) begin
        srv_vld_o <= 1'b0;
        srv_o <= ~srv_o;
        if (sys_rst_i) begin
            srv_o <= '0;
            s_busy_q <= 1'b0;
        end else if (s_busy_q && s_cnt_q == 4'h0) begin
            s_busy_q <= 1'b0;
            srv_vld_o <= 1'b1;
            srv_o.port <= s_req_q.port;
            if (s_req_q.eap[31:28] == 4'h1) begin
                srv_o.kind <= pag_pkg::PAG_SRV_CHALLENGE;
                srv_o.eap <= {4'h3, s_req_q.eap[27:0]};
            end else begin
                srv_o.kind <= srv_ok_i ? pag_pkg::PAG_SRV_ACCEPT :
                    pag_pkg::PAG_SRV_REJECT;
                srv_o.eap <= {srv_ok_i ? 4'h4 : 4'h5, s_req_q.eap[27:0]};
            end
        end else if (s_busy_q) begin
            s_cnt_q <= s_cnt_q - 4'h1;
        end else if (srv_tx_vld_i && srv_ans_i) begin
            s_busy_q <= 1'b1;
            s_cnt_q <= srv_dly_i;
            s_req_q <= srv_tx_i;
        end
    end
endmodule : pag_partner_model

// [sim/test_port_auth_gate.sv]
// self-checking bench for the port access gate
`timescale 1ns/100ps
module test_port_auth_gate;
    localparam logic [31:0] IP = 32'h0A0B0C0D; // arbitrary value
    localparam logic [31:0] ID = 32'h00001234; // arbitrary value
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] link_up = 8'h00;
    logic glob_en = 1'b1;
    logic [7:0] auto_en = 8'h7F;
    logic t_vld = 1'b0;
    pag_pkg::pag_cl_rx_t t_cl = '0;
    logic frm_vld = 1'b0;
    pag_pkg::pag_frm_t frm = '0;
    logic cl_ans = 1'b1;
    logic srv_ans = 1'b1;
    logic srv_ok = 1'b1;
    logic [3:0] srv_dly = 4'h0;
    logic p_vld, s_vld, cl_vld, sv_vld, pass, drop;
    logic [7:0] auth;
    pag_pkg::pag_cl_rx_t p_cl;
    pag_pkg::pag_srv_rx_t s_rx;
    pag_pkg::pag_cl_tx_t cl_tx;
    pag_pkg::pag_srv_tx_t sv_tx;
    pag_pkg::pag_cl_tx_t cl_q[$];
    pag_pkg::pag_srv_tx_t sv_q[$];
    int fail_count = 0;
    int samples_checked = 0;

    ////////////////////////////////////////////////////////////////
    // 250 MHz clock
    always #2 ref_clk_i = ~ref_clk_i;

    // short server timeout keeps the retry scenario brief
    pag_gate #(.NPORTS(8), .SRV_TO_CYC(36'h14), .NAS_IP(IP), .NAS_ID(ID))
    dut_u (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .link_up_i(link_up), .glob_en_i(glob_en),
        .auto_port_authentication_setting_i(auto_en),
        .cl_rx_vld_i(t_vld | p_vld), .cl_rx_i(t_vld ? t_cl : p_cl),
        .srv_rx_vld_i(s_vld), .srv_rx_i(s_rx),
        .frm_vld_i(frm_vld), .frm_i(frm),
        .cl_tx_vld_o(cl_vld), .cl_tx_o(cl_tx),
        .srv_tx_vld_o(sv_vld), .srv_tx_o(sv_tx),
        .frm_pass_o(pass), .frm_drop_o(drop), .port_auth_o(auth)
    );

    pag_partner_model far_u (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .cl_ans_i(cl_ans), .srv_ans_i(srv_ans), .srv_ok_i(srv_ok),
        .srv_dly_i(srv_dly), .cl_tx_vld_i(cl_vld), .cl_tx_i(cl_tx),
        .srv_tx_vld_i(sv_vld), .srv_tx_i(sv_tx),
        .cl_vld_o(p_vld), .cl_o(p_cl), .srv_vld_o(s_vld), .srv_o(s_rx)
    );

    // one-cycle pulses are caught mid-cycle, where they are settled
    always @(negedge ref_clk_i) begin
        if (cl_vld === 1'b1) cl_q.push_back(cl_tx);
        if (sv_vld === 1'b1) sv_q.push_back(sv_tx);
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [127:0] e, g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tick

    task automatic link(input pag_pkg::pag_port_t p, input logic v);
        @(posedge ref_clk_i);
        link_up[p] <= v;
    endtask : link

    task automatic cl_send(input pag_pkg::pag_port_t p,
            input pag_pkg::pag_eapol_t k);
        @(posedge ref_clk_i);
        t_vld <= 1'b1;
        t_cl <= {p, k, 32'h0};
        @(posedge ref_clk_i);
        t_vld <= 1'b0;
    endtask : cl_send

    // bounded wait for the next client frame; eap compared if ce
    task automatic exp_cl(input pag_pkg::pag_port_t p,
            input pag_pkg::pag_cl_kind_t k, input logic [31:0] e,
            input logic ce);
        pag_pkg::pag_cl_tx_t g;
        int n;
        for (n = 0; n < 60 && cl_q.size() == 0; n++) tick(1);
        g = (cl_q.size() == 0) ? 'x : cl_q.pop_front();
        chk("client port/kind", {p, k}, {g.port, g.kind});
        if (ce) chk("client eap", e, g.eap);
    endtask : exp_cl

    task automatic exp_sv(input pag_pkg::pag_port_t p, input logic [31:0] e);
        pag_pkg::pag_srv_tx_t g;
        int n;
        for (n = 0; n < 60 && sv_q.size() == 0; n++) tick(1);
        g = (sv_q.size() == 0) ? 'x : sv_q.pop_front();
        chk("server packet", {IP, ID, p, e}, g);
    endtask : exp_sv

    task automatic filt(input pag_pkg::pag_port_t p, input logic e, ok);
        @(posedge ref_clk_i);
        frm_vld <= 1'b1;
        frm <= {p, e};
        @(posedge ref_clk_i);
        frm_vld <= 1'b0;
        @(negedge ref_clk_i);
        chk("filter pass/drop", {ok, !ok}, {pass, drop});
    endtask : filt

    // full exchange after an identity request: id, challenge, verdict
    task automatic run_auth(input pag_pkg::pag_port_t p, input logic ok);
        logic [31:0] idw;
        idw = {28'h1ABCD00, 1'b0, p};
        srv_ok <= ok;
        exp_sv(p, idw);
        exp_cl(p, pag_pkg::PAG_TX_RELAY, {4'h3, idw[27:0]}, 1'b1);
        exp_sv(p, {4'h2, idw[27:0]});
        exp_cl(p, ok ? pag_pkg::PAG_TX_SUCCESS : pag_pkg::PAG_TX_FAILURE,
            32'h0, 1'b0);
        tick(1);
        chk("port open", ok, auth[p]);
    endtask : run_auth

    ////////////////////////////////////////////////////////////////
    task automatic scen_link_accept();
        chk("ports after reset", 8'h80, auth);
        filt(3'h1, 1'b1, 1'b1);
        filt(3'h1, 1'b0, 1'b0);
        link(3'h1, 1'b1);
        exp_cl(3'h1, pag_pkg::PAG_TX_REQ_ID, 32'h0, 1'b1);
        run_auth(3'h1, 1'b1);
        chk("ports", 8'h82, auth);
        filt(3'h1, 1'b0, 1'b1);
        filt(3'h2, 1'b0, 1'b0);
    endtask : scen_link_accept

    task automatic scen_logoff_retry();
        cl_send(3'h1, pag_pkg::PAG_EAPOL_LOGOFF);
        tick(3);
        chk("port open", 1'b0, auth[1]);
        srv_dly <= 4'h9;
        cl_send(3'h1, pag_pkg::PAG_EAPOL_START);
        exp_cl(3'h1, pag_pkg::PAG_TX_REQ_ID, 32'h0, 1'b1);
        run_auth(3'h1, 1'b0);
        srv_dly <= 4'h0;
        cl_send(3'h1, pag_pkg::PAG_EAPOL_START);
        exp_cl(3'h1, pag_pkg::PAG_TX_REQ_ID, 32'h0, 1'b1);
        run_auth(3'h1, 1'b1);
        link(3'h1, 1'b0);
        tick(6);
        chk("port open", 1'b0, auth[1]);
    endtask : scen_logoff_retry

    task automatic scen_timeout();
        srv_ans <= 1'b0;
        link(3'h3, 1'b1);
        exp_cl(3'h3, pag_pkg::PAG_TX_REQ_ID, 32'h0, 1'b1);
        repeat (3) exp_sv(3'h3, 32'h1ABCD003);
        exp_cl(3'h3, pag_pkg::PAG_TX_FAILURE, 32'h0, 1'b0);
        chk("port open", 1'b0, auth[3]);
        srv_ans <= 1'b1;
    endtask : scen_timeout

    task automatic scen_silent_disabled();
        cl_ans <= 1'b0;
        link(3'h4, 1'b1);
        exp_cl(3'h4, pag_pkg::PAG_TX_REQ_ID, 32'h0, 1'b1);
        tick(40);
        chk("server packets", 0, sv_q.size());
        filt(3'h4, 1'b0, 1'b0);
        link(3'h7, 1'b1);
        repeat (3) cl_send(3'h7, pag_pkg::PAG_EAPOL_START);
        tick(10);
        chk("client frames", 0, cl_q.size());
        filt(3'h7, 1'b1, 1'b0);
        filt(3'h7, 1'b0, 1'b1);
        tick(1);
        glob_en <= 1'b0;
        tick(3);
        chk("ports", 8'hFF, auth);
        filt(3'h4, 1'b0, 1'b1);
    endtask : scen_silent_disabled

    ////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    // main sequence
    initial begin
        tick(20);
        sys_rst_i <= 1'b0;
        tick(3);
        scen_link_accept();
        scen_logoff_retry();
        scen_timeout();
        scen_silent_disabled();
        give_verdict();
    end

    // the whole run needs a few hundred cycles; a hang stops here
    initial begin
        tick(20000);
        fail_count++;
        give_verdict();
    end
endmodule : test_port_auth_gate
